/* core/efmw_map.svh */
// Register offsets, field positions, reset values and timing counts of the event flag block.
// Assumes one 50 MHz clock; included by the package and the design file.
`ifndef EFMW_MAP_SVH
`define EFMW_MAP_SVH
// Offsets are register indices; the bus byte address is four times the index.
`define EFMW_PEND_OFF      8'h38
`define EFMW_MASK_OFF      8'h3A
`define EFMW_PERIOD_OFF    8'h3C
`define EFMW_TEST_OFF      8'h3E
`define EFMW_CTRL_OFF      8'h28
`define EFMW_TXMON_OFF     8'h29
`define EFMW_MASK_RST      16'hFFFF
`define EFMW_PERIOD_RST    16'h0800
`define EFMW_FLAG_W        14
`define EFMW_TXMON_W       16
`define EFMW_CTRL_KICK     0
`define EFMW_CTRL_STAMP    1
`define EFMW_TICK_NS       1000000
`define EFMW_CLK_NS        20
`define EFMW_TICK_CYC      (`EFMW_TICK_NS / `EFMW_CLK_NS)
`define EFMW_FAULT_MAX     16'hFFFF
`endif

/* core/efmw_pkg.sv */
// Types shared by the event flag block and its bench.
// Assumes the constants header sits beside it.
`include "efmw_map.svh"
package efmw_pkg;
    // Event strobes from the surrounding engines, one cycle each, except the transmit monitor levels and the fault counter value.
    typedef struct packed {
        logic        link_evt;      // Link engine event.
        logic        ci_rx_evt;     // Command/indicate receive event.
        logic        rx_mon_evt;    // Receive monitor event.
        logic [15:0] tx_mon_ind;    // Per-channel transmit monitor indications.
        logic        queue_full;    // One of the circular queues filled.
        logic        rx_warn;       // Receive FIFO three-quarters full.
        logic        rx_full;       // Receive FIFO full and stalled.
        logic        tx_warn;       // Transmit FIFO three-quarters full.
        logic        tx_full;       // Transmit FIFO full and stalled.
        logic        evq_warn;      // Status FIFO three-quarters full.
        logic        evq_full;      // Status FIFO full and stalled.
        logic        seq_lock;      // Pattern analyser locked.
        logic [15:0] fault_count;   // Sequence fault counter value.
    } efmw_events_t;
    // Watchdog state machine, Gray coded.
    typedef enum logic [1:0] {
        EFMW_RUN   = 2'b00,
        EFMW_FIRED = 2'b01
    } efmw_wd_t;
endpackage : efmw_pkg

/* core/efmw_core.sv */
// Event flag register, mask, interrupt request pin and watchdog time base.
// Assumes one 50 MHz clock, synchronous active-low reset and an AXI4-Lite master.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "efmw_map.svh"
module efmw_core (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire efmw_pkg::efmw_events_t ev,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic                     event_request_pin,
    output logic                     watchdog_out
);
    import efmw_pkg::*;

    // Register map as seen by software.
    // Every register sits in its own aligned 32-bit word; the word index on
    // address bits 7:2 is the register offset itself, so the byte address is
    // four times the offset.
    // Pending flags: read only, every read returns the flags and clears them.
    // Mask: read and write, a one blocks the matching flag from the pin.
    // Period: read and write, counted in milliseconds of the divided clock.
    // Factory test bits: stored and read back, they drive nothing.
    // Control: bit 0 restarts the watchdog when written as one, bit 1 holds
    // the stamp enable that parks the watchdog counter.
    // Transmit monitor source: read only, a read clears it.
    // Any other word answers with a slave error and has no effect.
    // A write to a read-only word also answers with a slave error.
    // Hazards the logic guards against.
    // An event that lands on the edge of a clearing read survives it, so
    // software never loses an event between its read and the next one.
    // The request pin is registered from the next flag value, so it rises on
    // the same edge as the flag and falls on the edge of the clearing read.
    // Only the lower half of a data word is used; byte lanes 3 and 2 are
    // ignored and the upper half always reads zero.

    // Register state.
    logic [`EFMW_FLAG_W-1:0]  flags_q;       // Pending event flags.
    logic [`EFMW_FLAG_W-1:0]  flags_d;       // Next pending event flags.
    logic [`EFMW_FLAG_W-1:0]  mask_q;        // Mask bits.
    logic [15:0]              period_q;      // Watchdog period in ticks.
    logic [15:0]              test_q;        // Factory test bits, stored only.
    logic                     stamp_q;       // Stamp enable.
    logic [`EFMW_TXMON_W-1:0] txsrc_q;       // Transmit monitor source bits.
    logic [`EFMW_TXMON_W-1:0] txmon_prev_q;  // Last transmit monitor levels.
    logic                     fault_prev_q;  // Last saturation compare.

    // AXI handshake state.
    logic       aw_hold_q;  // Write address taken.
    logic       w_hold_q;   // Write data taken.
    logic [7:0] awaddr_q;   // Latched write address.
    logic [31:0] wdata_q;   // Latched write data.
    logic [3:0] wstrb_q;    // Latched byte enables.

    // Watchdog counters.
    logic [15:0] tick_div_q;   // Cycles within one millisecond.
    logic [15:0] wd_cnt_q;     // Milliseconds since last restart or period end.
    efmw_wd_t    wd_state_q;   // Watchdog state.

    // Write decode, taken once both address and data are held.
    wire        wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire        wr_low    = wstrb_q[0];
    wire        wr_high   = wstrb_q[1];
    wire        wr_mask   = wr_fire && (awaddr_q[7:2] == 6'(`EFMW_MASK_OFF));
    wire        wr_period = wr_fire && (awaddr_q[7:2] == 6'(`EFMW_PERIOD_OFF));
    wire        wr_test   = wr_fire && (awaddr_q[7:2] == 6'(`EFMW_TEST_OFF));
    wire        wr_ctrl   = wr_fire && (awaddr_q[7:2] == 6'(`EFMW_CTRL_OFF));
    wire        wr_hit    = wr_mask || wr_period || wr_test || wr_ctrl;
    wire        kick      = wr_ctrl && wr_low && wdata_q[`EFMW_CTRL_KICK];

    // Read decode; a read of the pending flags clears them.
    wire        rd_fire   = s_axi_arvalid && s_axi_arready;
    wire [5:0]  rd_word   = s_axi_araddr[7:2];
    wire        rd_pend   = rd_fire && (rd_word == 6'(`EFMW_PEND_OFF));
    wire        rd_txsrc  = rd_fire && (rd_word == 6'(`EFMW_TXMON_OFF));
    logic [31:0] rd_val;
    logic        rd_ok;

    // Read data selection; upper bits of each word read zero.
    always_comb begin
        rd_ok  = 1'b1;
        unique case (rd_word)
            6'(`EFMW_PEND_OFF):   rd_val = {18'h0, flags_q};
            6'(`EFMW_MASK_OFF):   rd_val = {18'h0, mask_q};
            6'(`EFMW_PERIOD_OFF): rd_val = {16'h0, period_q};
            6'(`EFMW_TEST_OFF):   rd_val = {16'h0, test_q};
            6'(`EFMW_CTRL_OFF):   rd_val = {30'h0, stamp_q, 1'b0};
            6'(`EFMW_TXMON_OFF):  rd_val = {16'h0, txsrc_q};
            default: begin
                rd_val = 32'h0;
                rd_ok  = 1'b0;
            end
        endcase
    end

    // Event inputs, each setting its own flag.
    wire [`EFMW_TXMON_W-1:0] txmon_rise = ev.tx_mon_ind & ~txmon_prev_q;
    wire fault_sat  = (ev.fault_count == `EFMW_FAULT_MAX);
    wire tick_evt   = (wd_cnt_q == period_q) && (tick_div_q == 16'(`EFMW_TICK_CYC - 1))
                      && !stamp_q && !kick;
    wire [`EFMW_FLAG_W-1:0] set_vec = {
        fault_sat && !fault_prev_q,
        ev.seq_lock,
        tick_evt,
        ev.evq_full,
        ev.evq_warn,
        ev.tx_full,
        ev.tx_warn,
        ev.rx_full,
        ev.rx_warn,
        ev.queue_full,
        |txmon_rise,
        ev.rx_mon_evt,
        ev.ci_rx_evt,
        ev.link_evt
    };

    // Set wins over the clearing read.
    assign flags_d = (rd_pend ? '0 : flags_q) | set_vec;

    // Flag, source and edge history registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q      <= '0;
            txsrc_q      <= '0;
            txmon_prev_q <= '0;
            fault_prev_q <= 1'b0;
        end else begin
            flags_q      <= flags_d;
            txsrc_q      <= (rd_txsrc ? '0 : txsrc_q) | txmon_rise;
            txmon_prev_q <= ev.tx_mon_ind;
            fault_prev_q <= fault_sat;
        end
    end

    // Software registers; reserved mask bits never store.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // The two reserved mask bits are not stored, so they read zero.
            mask_q   <= 14'(`EFMW_MASK_RST);
            period_q <= `EFMW_PERIOD_RST;
            test_q   <= 16'h0000;
            stamp_q  <= 1'b0;
        end else begin
            if (wr_mask && wr_low)    mask_q[7:0]   <= wdata_q[7:0];
            if (wr_mask && wr_high)   mask_q[13:8]  <= wdata_q[13:8];
            if (wr_period && wr_low)  period_q[7:0] <= wdata_q[7:0];
            if (wr_period && wr_high) period_q[15:8] <= wdata_q[15:8];
            if (wr_test && wr_low)    test_q[7:0]   <= wdata_q[7:0];
            if (wr_test && wr_high)   test_q[15:8]  <= wdata_q[15:8];
            if (wr_ctrl && wr_low)    stamp_q       <= wdata_q[`EFMW_CTRL_STAMP];
        end
    end

    // Interrupt pin registered from next flag state, masked bits blocked.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_request_pin <= 1'b0;
        end else begin
            event_request_pin <= |(flags_d & ~mask_q);
        end
    end

    // Millisecond divider and period counter; a kick restarts both.
    // While stamping is enabled both stay at zero, so the period register
    // has no effect and neither a tick nor a watchdog firing can occur.
    // A period of zero gives a tick at the end of every millisecond.
    always_ff @(posedge aclk) begin
        if (!aresetn || kick || stamp_q) begin
            tick_div_q <= 16'h0000;
            wd_cnt_q   <= 16'h0000;
        end else if (tick_div_q == 16'(`EFMW_TICK_CYC - 1)) begin
            tick_div_q <= 16'h0000;
            wd_cnt_q   <= (wd_cnt_q == period_q) ? 16'h0000 : wd_cnt_q + 16'h0001;
        end else begin
            tick_div_q <= tick_div_q + 16'h0001;
        end
    end

    // Watchdog fires at the first period end and holds until kicked or until stamping is enabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_state_q   <= EFMW_RUN;
            watchdog_out <= 1'b0;
        end else begin
            unique case (wd_state_q)
                EFMW_RUN: begin
                    if (tick_evt) begin
                        wd_state_q   <= EFMW_FIRED;
                        watchdog_out <= 1'b1;
                    end
                end
                EFMW_FIRED: begin
                    if (kick || stamp_q) begin
                        wd_state_q   <= EFMW_RUN;
                        watchdog_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // AXI write channel: address and data held in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Ready is high while the matching half is not yet held.
    // Both readies stay low while a response waits, so only one write is
    // under way at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !wr_fire
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !wr_fire
                             && !s_axi_bvalid;
        end
    end

    // AXI read channel: one read at a time, answered the cycle after the take.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire && !s_axi_arready;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks.
    a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_pend && set_vec == '0 |=> flags_q == '0)
        else $error("pending flags not cleared by read");
    a_pin_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 event_request_pin == |($past(flags_d) & ~$past(mask_q)))
        else $error("request pin does not follow flags");
    a_link_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        ev.link_evt |=> flags_q[0])
        else $error("link event lost");
    a_tick_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_evt |=> flags_q[11] && watchdog_out)
        else $error("period end not flagged");
    a_stamp_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        stamp_q |-> !tick_evt)
        else $error("tick while stamping");
    a_fault_sat: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_sat && !fault_prev_q |=> flags_q[13])
        else $error("saturation not flagged");
    a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(rd_word) <= 6'(`EFMW_MASK_OFF)
        && $past(rd_word) >= 6'(`EFMW_PEND_OFF) |-> s_axi_rdata[31:14] == '0)
        else $error("reserved bits read nonzero");
    a_kick_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        kick |=> wd_cnt_q == 16'h0000 && tick_div_q == 16'h0000 ##1 !watchdog_out)
        else $error("kick did not restart watchdog");
    a_txmon_src: assert property (@(posedge aclk) disable iff (!aresetn)
        |txmon_rise |=> flags_q[3] && (txsrc_q != '0))
        else $error("transmit monitor not recorded");
    // A fully masked flag register can never raise the request pin.
    a_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        mask_q == '1 |=> !event_request_pin)
        else $error("masked flag reached the pin");
    // With stamping on, a quiet watchdog output stays quiet.
    a_stamp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        stamp_q && !watchdog_out |=> !watchdog_out)
        else $error("watchdog fired while stamping");
    c_read_clear: cover property (@(posedge aclk) rd_pend && flags_q != '0);
    c_wd_fire: cover property (@(posedge aclk) $rose(watchdog_out));
    c_pin_high: cover property (@(posedge aclk) $rose(event_request_pin));
    c_set_on_read: cover property (@(posedge aclk) rd_pend && set_vec != '0);
endmodule : efmw_core

/* verif/efmw_host.sv */
// Host processor model: an AXI4-Lite master with one write and one read task.
// Assumes the event flag block as slave on the same clock and a bench that calls the tasks.
`timescale 1ns/1ns
`include "efmw_map.svh"
module efmw_host (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    logic hung;  // Set when a transfer got no answer within the bound.

    // All master outputs are idle from time zero; the host never touches the test word.
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
        wstrb = 4'hF;
    end

    // Offers address and data together and holds each until its own handshake edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;  // Set once the response is taken.
        r = 2'b11;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 1000 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                r = bresp;
                done = 1'b1;
                bready <= 1'b0;
            end
        end
        if (!done) hung = 1'b1;
        // One edge passes so a following call never drives bready twice at once.
        @(posedge aclk);
    endtask : wr

    // Holds the read address until taken and rready until the data edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic done;  // Set once the read data is taken.
        r = 2'b11;
        done = 1'b0;
        d = '0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 1000 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                d = rdata;
                r = rresp;
                done = 1'b1;
                rready <= 1'b0;
            end
        end
        if (!done) hung = 1'b1;
        // One edge passes so a following call never drives rready twice at once.
        @(posedge aclk);
    endtask : rd
endmodule : efmw_host

/* verif/event_flags_mask_watchdog_bench.sv */
// Self-checking bench of the event flag block: registers, event sources, mask and watchdog.
// Assumes the design core, its package and the host model in efmw_host.
`timescale 1ns/1ns
`include "efmw_map.svh"
module event_flags_mask_watchdog_bench;
    import efmw_pkg::*;
    localparam logic [7:0] A_FLAG = 8'(`EFMW_PEND_OFF << 2);    // Pending flags word.
    localparam logic [7:0] A_MASK = 8'(`EFMW_MASK_OFF << 2);    // Mask word.
    localparam logic [7:0] A_PER  = 8'(`EFMW_PERIOD_OFF << 2);  // Period word.
    localparam logic [7:0] A_CTRL = 8'(`EFMW_CTRL_OFF << 2);    // Control word.
    localparam logic [7:0] A_TXS  = 8'(`EFMW_TXMON_OFF << 2);   // Transmit source word.
    logic aclk, aresetn, awready, wready, bvalid, bready, arready, rvalid, rready;
    logic awvalid, wvalid, arvalid, event_request_pin, watchdog_out;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    efmw_events_t ev;
    int failures = 0;
    int checks = 0;

    efmw_core uut (.aclk(aclk), .aresetn(aresetn), .ev(ev), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .event_request_pin(event_request_pin),
        .watchdog_out(watchdog_out));
    efmw_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // Free-running 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Reads a word and compares data and response; a hung bus ends the run.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        if (host.hung) begin
            failures++;
            end_sim();
        end
        chk(d, e, "read data");
        chk({30'h0, r}, {30'h0, re}, "read response");
    endtask : rd_chk

    // Writes a word and compares the response.
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re);
        logic [1:0] r;
        host.wr(a, d, r);
        if (host.hung) begin
            failures++;
            end_sim();
        end
        chk({30'h0, r}, {30'h0, re}, "write response");
    endtask : wr_chk

    // Builds a one-cycle event that should set flag bit b.
    function automatic efmw_events_t pulse(input int b);
        efmw_events_t e;
        e = '0;
        case (b)
            0: e.link_evt = 1'b1;
            1: e.ci_rx_evt = 1'b1;
            2: e.rx_mon_evt = 1'b1;
            3: e.tx_mon_ind[2] = 1'b1;
            4: e.queue_full = 1'b1;
            5: e.rx_warn = 1'b1;
            6: e.rx_full = 1'b1;
            7: e.tx_warn = 1'b1;
            8: e.tx_full = 1'b1;
            9: e.evq_warn = 1'b1;
            10: e.evq_full = 1'b1;
            12: e.seq_lock = 1'b1;
            13: e.fault_count = `EFMW_FAULT_MAX;
            default: e = '0;
        endcase
        return e;
    endfunction : pulse

    // Reset values, reserved bits and refused accesses.
    task automatic reset_and_refusals();
        rd_chk(A_MASK, 32'h3FFF, 2'b00);
        rd_chk(A_PER, 32'h0800, 2'b00);
        rd_chk(A_FLAG, 32'h0, 2'b00);
        wr_chk(A_FLAG, 32'h3FFF, 2'b10);
        rd_chk(A_FLAG, 32'h0, 2'b00);
        rd_chk(8'h80, 32'h0, 2'b10);
    endtask : reset_and_refusals

    // Each source except the watchdog tick alone sets its own flag, drives the pin, and a read clears it.
    task automatic each_source();
        int b;
        wr_chk(A_MASK, 32'h0, 2'b00);
        for (b = 0; b < 14; b++) begin
            if (b == 11) continue;
            @(posedge aclk);
            ev <= pulse(b);
            @(posedge aclk);
            ev <= '0;
            repeat (3) @(posedge aclk);
            chk({31'h0, event_request_pin}, 32'h1, "pin set");
            rd_chk(A_FLAG, 32'h1 << b, 2'b00);
            rd_chk(A_FLAG, 32'h0, 2'b00);
            chk({31'h0, event_request_pin}, 32'h0, "pin clear");
        end
        rd_chk(A_TXS, 32'h0004, 2'b00);
    endtask : each_source

    // A masked flag is still recorded but keeps the pin low.
    task automatic masked_flag();
        wr_chk(A_MASK, 32'h0001, 2'b00);
        @(posedge aclk);
        ev <= pulse(0);
        @(posedge aclk);
        ev <= '0;
        repeat (3) @(posedge aclk);
        chk({31'h0, event_request_pin}, 32'h0, "pin masked");
        rd_chk(A_FLAG, 32'h1, 2'b00);
        wr_chk(A_MASK, 32'hFFFF, 2'b00);
        rd_chk(A_MASK, 32'h3FFF, 2'b00);
    endtask : masked_flag

    // A zero-period watchdog fires, raises the tick flag, and a kick drops the output.
    task automatic watchdog_fire();
        int n;
        wr_chk(A_CTRL, 32'h1 << `EFMW_CTRL_KICK, 2'b00);
        wr_chk(A_PER, 32'h0000, 2'b00);
        for (n = 0; n < 60000 && watchdog_out !== 1'b1; n++) @(posedge aclk);
        if (n >= 60000) begin
            failures++;
            end_sim();
        end
        chk({31'h0, watchdog_out}, 32'h1, "watchdog fired");
        rd_chk(A_FLAG, 32'h1 << 11, 2'b00);
        wr_chk(A_CTRL, 32'h1 << `EFMW_CTRL_KICK, 2'b00);
        repeat (2) @(posedge aclk);
        chk({31'h0, watchdog_out}, 32'h0, "watchdog kicked");
    endtask : watchdog_fire

    // Main sequence: reset for eight cycles, then each scenario in turn.
    initial begin
        aresetn = 1'b0;
        ev = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reset_and_refusals();
        each_source();
        masked_flag();
        watchdog_fire();
        end_sim();
    end
endmodule : event_flags_mask_watchdog_bench
